/* File: contour_pkg.sv */
package contour_pkg;
  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int NUM_AXES     = 4;      // Physical contour axes.
  localparam int NUM_VIRT     = 2;      // Virtual axes with no feedback.
  localparam int NUM_ALL      = 6;      // Physical plus virtual axes.
  localparam int BUF_DEPTH    = 512;    // Buffer entries; one is held back.
  localparam int PTR_W        = 9;      // Buffer pointer width.
  localparam int INC_W        = 16;     // Signed increment width.
  localparam int POS_W        = 32;     // Commanded position width.
  localparam int REC_DEPTH    = 512;    // Records per capture array.
  localparam int NUM_REC      = 4;      // Capture destination arrays.
  // ------------------------------------------------------------------
  // Number limits
  // ------------------------------------------------------------------
  localparam logic signed [15:0] INC_MAX = 16'sd32000;   // Largest legal increment.
  localparam logic [8:0]  FREE_EMPTY   = 9'h1FF;   // Free count of an empty buffer.
  localparam logic [3:0]  EXP_MIN      = 4'h1;     // Smallest interval exponent.
  localparam logic [3:0]  EXP_MAX      = 4'h8;     // Largest interval exponent.
  localparam logic [3:0]  EXP_RESET    = 4'h1;     // Exponent held after reset.
  // ------------------------------------------------------------------
  // Register map, byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;  // contour_axis_select, pause, exponent.
  localparam logic [7:0] REG_INC_BASE  = 8'h04;  // increment_entry axis 0..3 data.
  localparam logic [7:0] REG_PUSH      = 8'h14;  // Push entry; bits 5:0 interval code.
  localparam logic [7:0] REG_STATUS    = 8'h18;  // buffer_free_count and flags.
  localparam logic [7:0] REG_POS_BASE  = 8'h20;  // Commanded position 0..5.
  localparam logic [7:0] REG_REC_CTRL  = 8'h40;  // record_control.
  localparam logic [7:0] REG_REC_SEL   = 8'h44;  // record_array_select.
  localparam logic [7:0] REG_REC_ADDR  = 8'h48;  // Record readback index.
  localparam logic [7:0] REG_REC_DATA  = 8'h4C;  // Record readback data.
  localparam logic [7:0] REG_VIRT_BASE = 8'h50;  // Virtual move target 0..1.
  localparam logic [7:0] REG_CAM       = 8'h58;  // cam_master_select.
  localparam logic [7:0] REG_VIRT_CMD  = 8'h5C;  // Virtual axis command.
  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTRL_SEL_LSB  = 0;   // Axis select, four bits.
  localparam int CTRL_PAUSE    = 4;   // Pause bit.
  localparam int PUSH_HAS_EXP  = 4;   // Push carries an interval code.
  localparam int PUSH_PAUSE    = 5;   // Push code of minus one.
  localparam int ST_ACTIVE     = 16;  // Contour mode active.
  localparam int ST_WAIT       = 17;  // Waiting for data.
  localparam int ST_REC        = 18;  // Recording flag.
  localparam int RC_EXP_LSB    = 0;   // Capture exponent, four bits.
  localparam int RC_CNT_LSB    = 8;   // Record count, ten bits.
  localparam int VC_AXIS       = 0;   // Virtual axis index.
  localparam int VC_OP_LSB     = 1;   // Virtual op code, two bits.
  // ------------------------------------------------------------------
  // Virtual axis commands
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {VOP_STOP, VOP_JOG, VOP_REL, VOP_ABS} virt_op_e;
endpackage

/* File: contour_entry_if.sv */
`timescale 1ns/100ps
// Entry stream between the register front and the interpolation engine.
interface contour_entry_if;
  logic                                          valid;  // Entry waiting.
  logic                                          take;   // Engine consumes entry.
  logic signed [contour_pkg::INC_W-1:0]          inc [contour_pkg::NUM_AXES];  // Increments.
  logic [3:0]                                    exp_code;  // Exponent, zero ends mode.
  logic                                          is_end;    // All zero, buffer end.
  modport src (output valid, output inc, output exp_code, output is_end, input take);
  modport dst (input valid, input inc, input exp_code, input is_end, output take);
endinterface

/* File: contour_engine.sv */
`timescale 1ns/100ps
// Linear interpolator: one step per sample, remainder carried.
module contour_engine #(
  parameter int NUM_AXES = contour_pkg::NUM_AXES
) (
  input  wire logic                            i_clk,
  input  wire logic                            i_rst_n,
  input  wire logic                            i_sample,
  input  wire logic                            i_start,
  input  wire logic [NUM_AXES-1:0]             i_select,
  input  wire logic                            i_pause,
  contour_entry_if.dst                         ent,
  output logic                                 o_active,
  output logic                                 o_waiting,
  output logic [NUM_AXES-1:0]                  o_step_en,
  output logic signed [contour_pkg::POS_W-1:0] o_step [NUM_AXES]
);
  // ------------------------------------------------------------------
  // Segment state
  // ------------------------------------------------------------------
  logic                          running;      // A segment is in progress.
  logic [8:0]                    left;         // Samples left in segment.
  logic [3:0]                    seg_exp;      // Exponent of current segment.
  logic signed [contour_pkg::INC_W-1:0] seg_inc [NUM_AXES];  // Current increments.
  logic signed [contour_pkg::INC_W+8:0] acc [NUM_AXES];      // Applied-so-far times span.

  // Entry accepted at a sample when idle, active and not paused.
  assign ent.take = i_sample && !running && o_active && !i_pause && ent.valid;
  assign o_waiting = o_active && !running && !ent.valid;

  // ------------------------------------------------------------------
  // Mode: the front raises active on select; an end entry or exponent zero drops it.
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_active <= 1'b0;
    end else if (i_start && |i_select && !o_active) begin
      o_active <= 1'b1;
    end else if (i_select == '0) begin
      o_active <= 1'b0;
    end else if (ent.take && (ent.is_end || ent.exp_code == 4'h0)) begin
      o_active <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Segment counter: duration is two to the exponent samples.
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      running <= 1'b0;
      left    <= 9'h000;
      seg_exp <= contour_pkg::EXP_RESET;
    end else if (ent.take && !ent.is_end && ent.exp_code != 4'h0) begin
      running <= 1'b1;
      seg_exp <= ent.exp_code;
      left    <= 9'(9'h001 << ent.exp_code);
    end else if (running && i_sample) begin
      left    <= left - 9'h001;
      running <= (left != 9'h001);
    end
  end

  // ------------------------------------------------------------------
  // Per-axis step: the applied target i*inc/2^n is rounded down, so the
  // sum over the segment is exactly inc with no drift.
  // ------------------------------------------------------------------
  for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
    logic signed [contour_pkg::INC_W+8:0] next_acc;  // Accumulator after this sample.
    logic signed [contour_pkg::POS_W-1:0] old_pos, new_pos;
    always_comb begin
      next_acc = acc[a] + 25'(seg_inc[a]);
      old_pos  = 32'(acc[a] >>> seg_exp);
      new_pos  = 32'(next_acc >>> seg_exp);
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        acc[a]       <= '0;
        seg_inc[a]   <= '0;
        o_step[a]    <= '0;
        o_step_en[a] <= 1'b0;
      end else begin
        o_step_en[a] <= 1'b0;
        if (ent.take) begin
          acc[a]     <= '0;
          seg_inc[a] <= ent.inc[a];
        end else if (running && i_sample && i_select[a]) begin
          acc[a]       <= next_acc;
          o_step[a]    <= new_pos - old_pos;
          o_step_en[a] <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: contour_interpolator.sv */
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
// How it works
// - Only selected axes follow the contour.
// - Entries hold signed increments within 32000; the push does not check this and stores any 16-bit value.
// - All-zero entry ends the contour buffer.
// - Segment lasts two to the exponent samples.
// - Exponent zero leaves contour mode.
// - Missing exponent reuses the last one.
// - Free count reads 511 when empty.
// - One interpolated point each sample.
// - Empty buffer: wait, no motion.
// - Interval minus one pauses the buffer.
// - Axis select clears the buffer.
// - Capture every 2^n samples, stop after count.
// - Recording flag reads one while capturing.
// - Up to four simultaneous capture arrays.
// - Captured positions readable for playback differencing.
// - Two virtual axes take jog and moves.
// - Virtual axis can be cam master.
module contour_interpolator (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_sample,       // One-cycle servo sample tick.
  input  wire logic [31:0] i_fb_pos [contour_pkg::NUM_AXES],  // Encoder positions.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic      [31:0] o_cmd_pos [contour_pkg::NUM_AXES],  // Commanded positions.
  output logic      [31:0] o_cam_master_pos,                   // Master feed for the cam.
  output logic             o_contour_active
);
  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic [1:0] rst_sync;  // Two-stage release of the reset.
  logic       rst_n;     // Released reset for the rest of the block.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) rst_sync <= 2'b00;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  logic req;     // A new request this cycle.
  logic wr;      // A write takes effect.
  assign req = cyc_i && stb_i && !ack_o;
  assign wr  = req && we_i && sel_i[0];

  // Acknowledge one cycle after the request, dropped the next cycle.
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) ack_o <= 1'b0;
    else ack_o <= req;
  end

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  logic [3:0]  axis_select;   // contour_axis_select.
  logic        pause;         // Buffer consumption held.
  logic [3:0]  interval_exponent;  // Held exponent.
  logic signed [15:0] inc_stage [contour_pkg::NUM_AXES];  // Staged increments.
  logic        sel_pulse;     // Axis select written this cycle.
  assign sel_pulse = wr && adr_i == contour_pkg::REG_CTRL;
  logic        start;         // Select was written last cycle.

  // Only a select write may start the mode; an emptied buffer must not restart it.
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) start <= 1'b0;
    else start <= sel_pulse;
  end

  // Writes to control and staged increments.
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      axis_select       <= 4'h0;
      pause             <= 1'b0;
      interval_exponent <= contour_pkg::EXP_RESET;
      for (int i = 0; i < contour_pkg::NUM_AXES; i++) inc_stage[i] <= 16'h0000;
    end else if (wr) begin
      if (adr_i == contour_pkg::REG_CTRL) begin
        axis_select <= dat_i[contour_pkg::CTRL_SEL_LSB +: 4];
        pause       <= dat_i[contour_pkg::CTRL_PAUSE];
      end
      if (adr_i == contour_pkg::REG_PUSH && dat_i[contour_pkg::PUSH_PAUSE]) begin
        pause <= 1'b1;
      end else if (adr_i == contour_pkg::REG_PUSH && dat_i[contour_pkg::PUSH_HAS_EXP]) begin
        interval_exponent <= dat_i[3:0];
      end
      for (int i = 0; i < contour_pkg::NUM_AXES; i++) begin
        if (adr_i == 8'(contour_pkg::REG_INC_BASE + 4 * i)) begin
          inc_stage[i] <= dat_i[15:0];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Contour buffer
  // ------------------------------------------------------------------
  logic [63:0] buf_inc [contour_pkg::BUF_DEPTH];  // Four packed increments.
  logic [3:0]  buf_exp [contour_pkg::BUF_DEPTH];  // Exponent per entry.
  logic [8:0]  wptr, rptr;                        // Write and read pointers.
  logic [8:0]  used;                              // Entries held.
  logic        push;                              // Legal entry written.
  logic [3:0]  push_exp;                          // Exponent stored with it.
  contour_entry_if ent ();

  assign push_exp = (dat_i[contour_pkg::PUSH_HAS_EXP]) ? dat_i[3:0] : interval_exponent;
  assign push = wr && adr_i == contour_pkg::REG_PUSH && !dat_i[contour_pkg::PUSH_PAUSE]
                && used != contour_pkg::FREE_EMPTY;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      buf_inc[wptr] <= {inc_stage[3], inc_stage[2], inc_stage[1], inc_stage[0]};
      buf_exp[wptr] <= push_exp;
    end
  end

  // Pointers; a select write empties the buffer.
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= 9'h000;
      rptr <= 9'h000;
      used <= 9'h000;
    end else if (sel_pulse) begin
      wptr <= 9'h000;
      rptr <= 9'h000;
      used <= 9'h000;
    end else begin
      if (push) wptr <= wptr + 9'h001;
      if (ent.take) rptr <= rptr + 9'h001;
      used <= used + {8'h00, push} - {8'h00, ent.take};
    end
  end

  assign ent.valid    = used != 9'h000;
  assign ent.exp_code = buf_exp[rptr];
  assign ent.is_end   = buf_inc[rptr] == 64'h0 && buf_exp[rptr] == 4'h0;
  for (genvar a = 0; a < contour_pkg::NUM_AXES; a++) begin : g_unpack
    assign ent.inc[a] = buf_inc[rptr][16*a +: 16];
  end

  // ------------------------------------------------------------------
  // Engine and commanded positions
  // ------------------------------------------------------------------
  logic        eng_waiting;
  logic [3:0]  step_en;
  logic signed [31:0] step [contour_pkg::NUM_AXES];
  contour_engine #(.NUM_AXES(contour_pkg::NUM_AXES)) u_engine (
    .i_clk     (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_sample  (i_sample),
    .i_start   (start),
    .i_select  (axis_select),
    .i_pause   (pause),
    .ent       (ent),
    .o_active  (o_contour_active),
    .o_waiting (eng_waiting),
    .o_step_en (step_en),
    .o_step    (step)
  );

  // Non-selected axes are left to other modes through direct position writes.
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < contour_pkg::NUM_AXES; i++) o_cmd_pos[i] <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < contour_pkg::NUM_AXES; i++) begin
        if (step_en[i]) o_cmd_pos[i] <= o_cmd_pos[i] + step[i];
        else if (wr && !axis_select[i] && adr_i == 8'(contour_pkg::REG_POS_BASE + 4 * i))
          o_cmd_pos[i] <= dat_i;
      end
    end
  end

  // ------------------------------------------------------------------
  // Virtual axes: no encoder, no output stage, profile only.
  // ------------------------------------------------------------------
  logic [31:0] virt_pos [contour_pkg::NUM_VIRT];    // Profile positions.
  logic [31:0] virt_tgt [contour_pkg::NUM_VIRT];    // Move targets or jog rates.
  logic [1:0]  virt_op  [contour_pkg::NUM_VIRT];    // Active motion op.
  logic        cam_master;                          // Which virtual axis is master.
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cam_master <= 1'b0;
      o_cam_master_pos <= 32'h0000_0000;
      for (int v = 0; v < contour_pkg::NUM_VIRT; v++) begin
        virt_pos[v] <= 32'h0000_0000;
        virt_tgt[v] <= 32'h0000_0000;
        virt_op[v]  <= contour_pkg::VOP_STOP;
      end
    end else begin
      if (wr && adr_i == contour_pkg::REG_CAM) cam_master <= dat_i[0];
      o_cam_master_pos <= virt_pos[cam_master];
      for (int v = 0; v < contour_pkg::NUM_VIRT; v++) begin
        if (wr && adr_i == 8'(contour_pkg::REG_VIRT_BASE + 4 * v)) virt_tgt[v] <= dat_i;
        if (wr && adr_i == contour_pkg::REG_VIRT_CMD && dat_i[contour_pkg::VC_AXIS] == v[0]) begin
          virt_op[v] <= dat_i[contour_pkg::VC_OP_LSB +: 2];
          if (dat_i[contour_pkg::VC_OP_LSB +: 2] == contour_pkg::VOP_REL)
            virt_tgt[v] <= virt_pos[v] + virt_tgt[v];
        end else if (i_sample) begin
          // Jog adds its rate each sample; moves step one count toward target.
          case (virt_op[v])
            contour_pkg::VOP_JOG: virt_pos[v] <= virt_pos[v] + virt_tgt[v];
            contour_pkg::VOP_REL,
            contour_pkg::VOP_ABS: begin
              if ($signed(virt_pos[v]) < $signed(virt_tgt[v])) virt_pos[v] <= virt_pos[v] + 32'h1;
              else if (virt_pos[v] != virt_tgt[v]) virt_pos[v] <= virt_pos[v] - 32'h1;
              else virt_op[v] <= contour_pkg::VOP_STOP;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Automatic capture
  // ------------------------------------------------------------------
  logic [31:0] rec_mem [contour_pkg::NUM_REC][contour_pkg::REC_DEPTH];  // Record arrays.
  logic [3:0]  rec_enable;   // record_array_select enables.
  logic [7:0]  rec_src;      // Two-bit source per array.
  logic        recording;    // Capture running.
  logic [3:0]  rec_exp;      // Capture exponent.
  logic [9:0]  rec_left;     // Records still to take.
  logic [8:0]  rec_idx;      // Next record slot.
  logic [8:0]  rec_tick;     // Sample counter in interval.
  logic [8:0]  rd_idx;       // Readback index.
  logic [1:0]  rd_arr;       // Readback array.
  logic        rec_fire;     // Store a record this cycle.
  assign rec_fire = recording && i_sample && rec_tick == 9'h000;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_enable <= 4'h0;
      rec_src    <= 8'h00;
      recording  <= 1'b0;
      rec_exp    <= 4'h0;
      rec_left   <= 10'h000;
      rec_idx    <= 9'h000;
      rec_tick   <= 9'h000;
      rd_idx     <= 9'h000;
      rd_arr     <= 2'b00;
    end else begin
      if (wr && adr_i == contour_pkg::REG_REC_SEL) {rec_src, rec_enable} <= dat_i[11:0];
      if (wr && adr_i == contour_pkg::REG_REC_ADDR) {rd_arr, rd_idx} <= dat_i[10:0];
      if (wr && adr_i == contour_pkg::REG_REC_CTRL) begin
        rec_exp   <= dat_i[contour_pkg::RC_EXP_LSB +: 4];
        rec_left  <= dat_i[contour_pkg::RC_CNT_LSB +: 10];
        recording <= dat_i[contour_pkg::RC_CNT_LSB +: 10] != 10'h000;
        rec_idx   <= 9'h000;
        rec_tick  <= 9'h000;
      end else if (recording && i_sample) begin
        rec_tick <= (rec_tick == 9'((9'h001 << rec_exp) - 9'h001)) ? 9'h000 : rec_tick + 9'h001;
        if (rec_fire) begin
          rec_idx   <= rec_idx + 9'h001;
          rec_left  <= rec_left - 10'h001;
          recording <= rec_left != 10'h001;
        end
      end
    end
  end

  for (genvar r = 0; r < contour_pkg::NUM_REC; r++) begin : g_rec
    always_ff @(posedge i_ref_clk) begin
      if (rec_fire && rec_enable[r]) rec_mem[r][rec_idx] <= i_fb_pos[rec_src[2*r +: 2]];
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_o <= 32'h0000_0000;
    end else if (req) begin
      dat_o <= 32'h0000_0000;  // Unmapped addresses read zero.
      case (adr_i)
        contour_pkg::REG_CTRL:     dat_o <= {23'h0, interval_exponent, pause, axis_select};
        contour_pkg::REG_STATUS:   dat_o <= {13'h0, recording, eng_waiting, o_contour_active,
                                             7'h0, 9'(contour_pkg::FREE_EMPTY - used)};
        contour_pkg::REG_REC_DATA: dat_o <= rec_mem[rd_arr][rd_idx];
        contour_pkg::REG_CAM:      dat_o <= {31'h0, cam_master};
        contour_pkg::REG_REC_SEL:  dat_o <= {20'h0, rec_src, rec_enable};
        default: begin
          for (int i = 0; i < contour_pkg::NUM_AXES; i++)
            if (adr_i == 8'(contour_pkg::REG_POS_BASE + 4 * i)) dat_o <= o_cmd_pos[i];
          for (int v = 0; v < contour_pkg::NUM_VIRT; v++)
            if (adr_i == 8'(contour_pkg::REG_POS_BASE + 16 + 4 * v)) dat_o <= virt_pos[v];
        end
      endcase
    end
  end
endmodule

/* File: sample_feed.sv */
`timescale 1ns/100ps
// Stands in for the amplifiers: a servo tick every PERIOD clocks and encoders that creep.
module sample_feed #(
  parameter int PERIOD = 8  // Clocks per servo sample.
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  output logic      o_sample,
  output logic [31:0] o_fb_pos [contour_pkg::NUM_AXES]
);
  int cnt;  // Clock count inside one sample period.
  int ticks;  // Samples seen since reset.
  // One-cycle tick; counted so the encoder model follows it.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 0;
      ticks <= 0;
      o_sample <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      o_sample <= (cnt == PERIOD - 1);
      ticks <= ticks + int'(o_sample);
    end
  end
  // Each axis is offset so captured records differ between arrays.
  always_comb begin
    for (int a = 0; a < contour_pkg::NUM_AXES; a++) begin
      o_fb_pos[a] = 32'(ticks + a * 256);
    end
  end
endmodule

/* File: contour_interpolator_sva.sv */
`timescale 1ns/100ps
module contour_interpolator_chk (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  input wire logic        i_sample,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [31:0] o_cmd_pos [contour_pkg::NUM_AXES],
  input wire logic        o_contour_active
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic req = cyc_i && stb_i;  // Request held by the master.
  wire logic wr_ctrl = req && we_i && adr_i == contour_pkg::REG_CTRL;  // Axis select write.
  AST_ACK_NEXT: assert property (req && !ack_o |=> ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack too long");
  AST_ACK_HELD: assert property (ack_o |-> req) else $error("ack without request");
  AST_ACK_IDLE: assert property (!cyc_i |=> !ack_o) else $error("ack while idle");
  AST_DAT_HOLD: assert property (!cyc_i |=> $stable(dat_o)) else $error("read data moved");
  // Outside bus cycles only a tick moves axis 0; whether the buffer is empty or paused is not checked.
  AST_POS_HOLD: assert property (!i_sample && !$past(i_sample) && !cyc_i |=> $stable(o_cmd_pos[0]))
    else $error("axis moved without tick");
  AST_ACT_RISE: assert property ($rose(o_contour_active) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
    else $error("active rose without select");
  AST_ACT_FALL: assert property ($fell(o_contour_active) |-> $past(wr_ctrl) || $past(wr_ctrl, 2)
    || $past(i_sample) || $past(i_sample, 2) || $past(i_sample, 3)) else $error("active fell");
endmodule
bind contour_interpolator contour_interpolator_chk u_chk (.i_ref_clk, .i_rst_n, .i_sample, .cyc_i,
  .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .o_cmd_pos, .o_contour_active);

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, smp, act;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat, cam, first;
  logic [31:0] fb [contour_pkg::NUM_AXES];
  logic [31:0] pos [contour_pkg::NUM_AXES];
  int          errors = 0, samples_checked = 0, cycles = 0;
  initial forever #2 ref_clk = ~ref_clk;
  sample_feed u_sample_feed (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .o_sample(smp), .o_fb_pos(fb));
  contour_interpolator u_contour_interpolator (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_sample(smp),
    .i_fb_pos(fb), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat),
    .dat_o(dat), .ack_o(ack), .o_cmd_pos(pos), .o_cam_master_pos(cam), .o_contour_active(act));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge ref_clk); while (ack !== 1'b1);
    rdat = dat;
    {cyc, stb} <= 2'b00;
    @(posedge ref_clk);
  endtask
  // Reads a register until the masked value appears, bounded, then compares.
  task automatic poll(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while ((rdat & m) !== e && n < 300);
    check(what, rdat & m, e);
  endtask
  task automatic test_done;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // A hang counts as a mismatch.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    poll("free", contour_pkg::REG_STATUS, 32'h1FF, 32'h1FF);
    bus(1'b1, contour_pkg::REG_CTRL, 32'h1);
    bus(1'b1, contour_pkg::REG_PUSH, 32'h20);
    bus(1'b1, contour_pkg::REG_INC_BASE, 32'd48);
    bus(1'b1, contour_pkg::REG_PUSH, 32'h12);
    // Several ticks pass; a paused buffer must keep its entry.
    repeat (40) @(posedge ref_clk);
    poll("paused", contour_pkg::REG_STATUS, 32'h1FF, 32'h1FE);
    bus(1'b1, contour_pkg::REG_CTRL, 32'h1);
    poll("cleared", contour_pkg::REG_STATUS, 32'h1FF, 32'h1FF);
    bus(1'b1, contour_pkg::REG_INC_BASE, 32'd48);
    bus(1'b1, contour_pkg::REG_PUSH, 32'h12);
    bus(1'b1, contour_pkg::REG_INC_BASE, 32'd240);
    bus(1'b1, contour_pkg::REG_PUSH, 32'h13);
    bus(1'b1, contour_pkg::REG_INC_BASE, 32'd40);
    bus(1'b1, contour_pkg::REG_PUSH, 32'h00);
    bus(1'b1, contour_pkg::REG_INC_BASE, 32'd0);
    bus(1'b1, contour_pkg::REG_PUSH, 32'h10);
    poll("done", contour_pkg::REG_STATUS, 32'h101FF, 32'h001FF);
    check("axis0", pos[0], 32'd328);
    check("axis1", pos[1], 32'd0);
    // Arrays 0 and 1 take encoders 0 and 1, which sit 256 counts apart.
    bus(1'b1, contour_pkg::REG_REC_SEL, 32'h43);
    bus(1'b1, contour_pkg::REG_REC_CTRL, 32'h301);
    poll("rec on", contour_pkg::REG_STATUS, 32'h40000, 32'h40000);
    poll("rec off", contour_pkg::REG_STATUS, 32'h40000, 32'h0);
    bus(1'b1, contour_pkg::REG_REC_ADDR, 32'h0);
    bus(1'b0, contour_pkg::REG_REC_DATA, 32'h0);
    first = rdat;
    bus(1'b1, contour_pkg::REG_REC_ADDR, 32'h2);
    bus(1'b0, contour_pkg::REG_REC_DATA, 32'h0);
    check("rec gap", rdat - first, 32'd4);
    bus(1'b1, contour_pkg::REG_REC_ADDR, 32'h200);
    bus(1'b0, contour_pkg::REG_REC_DATA, 32'h0);
    check("rec src", rdat - first, 32'd256);
    bus(1'b1, contour_pkg::REG_VIRT_BASE, 32'd5);
    bus(1'b1, contour_pkg::REG_VIRT_CMD, 32'h4);
    poll("virt", 8'h30, 32'hFFFFFFFF, 32'd5);
    check("cam", cam, 32'd5);
    bus(1'b1, contour_pkg::REG_CAM, 32'h1);
    check("cam1", cam, 32'd0);
    test_done();
  end
endmodule
